//--- rtl/eis_line_mux.sv
// per-line pin mux: decode selector into port and pin
`timescale 1ns/1ps
`default_nettype none
module eis_line_mux (
  input wire logic [15:0] port_a_i,
  input wire logic [15:0] port_b_i,
  input wire logic [15:0] port_c_i,
  input wire logic [15:0] port_d_i,
  eis_route_if.mux rt
);
  import eis_pkg::*;
  logic [3:0] pin;
  logic [1:0] port;
  assign pin = rt.sel[5:2];
  assign port = rt.sel[1:0];
  always_comb begin
    unique case (port)
      EIS_PORT_A: rt.level = port_a_i[pin];
      EIS_PORT_B: rt.level = port_b_i[pin];
      // unbonded codes read zero, never a floating pad
      EIS_PORT_C: rt.level = (pin >= 4'hD) ? port_c_i[pin] : 1'b0;
      EIS_PORT_D: rt.level = (pin == 4'h0 || pin >= 4'hC) ? port_d_i[pin] : 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/eis_pkg.sv
// constants for the interrupt line source select block
// Functional notes
// - six-bit selector at bits 29:24 picks the pin for line 15.
// - six-bit selector at bits 21:16 picks the pin for line 14.
// - six-bit selector at bits 13:8 picks the pin for line 13.
// - six-bit selector at bits 5:0 picks the pin for line 12.
// - upper four bits are pin number, lower two bits the port A,B,C,D.
// - port C routes only pins 13 to 15; absent pins give zero.
// - port D routes only pin 0 and pins 12 to 15.
// - select word at 0x10 resets to zero, every line on port A pin 0.
// - tolerance word at 0x14 holds 25 read-write bits, upper bits reserved.
// - tolerance bits are active low: zero enables high-voltage tolerance.
package eis_pkg;
  localparam logic [7:0] EIS_OFF_SEL = 8'h10;
  localparam logic [7:0] EIS_OFF_TOL = 8'h14;
  localparam logic [31:0] EIS_SEL_RST = 32'h00000000;
  localparam logic [31:0] EIS_TOL_RST = 32'h00000000;
  localparam int EIS_SEL_W = 6;
  localparam int EIS_LINES = 4;
  localparam int EIS_LINE_STRIDE = 8;
  localparam int EIS_TOL_W = 25;
  localparam logic [31:0] EIS_SEL_MASK = 32'h3F3F3F3F;
  localparam logic [1:0] EIS_PORT_A = 2'h0;
  localparam logic [1:0] EIS_PORT_B = 2'h1;
  localparam logic [1:0] EIS_PORT_C = 2'h2;
  localparam logic [1:0] EIS_PORT_D = 2'h3;
endpackage

//--- rtl/eis_route_if.sv
// interface carrying one line's selector and its routed level
`timescale 1ns/1ps
`default_nettype none
interface eis_route_if;
  logic [5:0] sel;
  logic level;
  modport ctrl (output sel, input level);
  modport mux (input sel, output level);
endinterface
`default_nettype wire

//--- rtl/eis_top.sv
// register file and routing for interrupt lines 12 to 15
`timescale 1ns/1ps
`default_nettype none
module eis_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [15:0] port_a_i,
  input wire logic [15:0] port_b_i,
  input wire logic [15:0] port_c_i,
  input wire logic [15:0] port_d_i,
  output logic [eis_pkg::EIS_LINES-1:0] line_level_o,
  output logic [eis_pkg::EIS_TOL_W-1:0] tolerance_enable_n_o
);
  import eis_pkg::*;
  logic [31:0] sel_q;
  logic [EIS_TOL_W-1:0] tol_q;
  logic [EIS_LINES-1:0] lvl;
  ////////////////////////////////////////////////////////////////
  // register writes; reserved gaps are masked so they stay zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q <= EIS_SEL_RST;
    end else if (wr_i && addr_i == EIS_OFF_SEL) begin
      sel_q <= wdata_i & EIS_SEL_MASK;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tol_q <= EIS_TOL_RST[EIS_TOL_W-1:0];
    end else if (wr_i && addr_i == EIS_OFF_TOL) begin
      tol_q <= wdata_i[EIS_TOL_W-1:0];
    end
  end
  // active low straight from the register: zero means tolerant
  assign tolerance_enable_n_o = tol_q;
  ////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      unique case (addr_i)
        EIS_OFF_SEL: rdata_o <= sel_q;
        EIS_OFF_TOL: rdata_o <= {7'h00, tol_q};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
  ////////////////////////////////////////////////////////////////
  // one mux per line; output flopped so pins reach the edge detector cleanly
  for (genvar g = 0; g < EIS_LINES; g++) begin : g_line
    eis_route_if rt ();
    assign rt.sel = sel_q[g*EIS_LINE_STRIDE +: EIS_SEL_W];
    eis_line_mux u_mux (
      .port_a_i(port_a_i),
      .port_b_i(port_b_i),
      .port_c_i(port_c_i),
      .port_d_i(port_d_i),
      .rt(rt)
    );
    assign lvl[g] = rt.level;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_level_o <= '0;
    end else begin
      line_level_o <= lvl;
    end
  end
  ////////////////////////////////////////////////////////////////
  // routing checks also want the sampled reset high: a release on an edge
  // leaves the flops in reset for that edge, so the level lags one more cycle
  a_sel_reset: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> sel_q == 32'h0)
    else $error("select word not zero after reset");
  a_gap_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sel_q & ~EIS_SEL_MASK) == 32'h0)
    else $error("reserved gap bits set");
  a_line15_route: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_n_i && sel_q[29:24] == 6'h3F |=> line_level_o[3] == $past(port_d_i[15]))
    else $error("line 15 misrouted");
  a_line14_pa0: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_n_i && sel_q[21:16] == 6'h00 |=> line_level_o[2] == $past(port_a_i[0]))
    else $error("line 14 misrouted");
  a_line13_pb: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_n_i && sel_q[9:8] == 2'h1 |=>
    line_level_o[1] == $past(port_b_i[sel_q[13:10]]))
    else $error("line 13 misrouted");
  a_line12_pc15: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_n_i && sel_q[5:0] == 6'h3E |=> line_level_o[0] == $past(port_c_i[15]))
    else $error("line 12 misrouted");
  a_absent_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rst_n_i && sel_q[1:0] == 2'h2 && sel_q[5:2] < 4'hD) |=> !line_level_o[0])
    else $error("absent pin not zero");
  a_tol_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == EIS_OFF_TOL) |=> tolerance_enable_n_o == $past(wdata_i[24:0]))
    else $error("tolerance write lost");
  a_sel_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == EIS_OFF_SEL) |=> rdata_o == $past(sel_q))
    else $error("select readback wrong");
endmodule
`default_nettype wire

//--- test/eis_pin_model.sv
// pin level model for the four ports feeding the line muxes
`timescale 1ns/1ps
`default_nettype none
module eis_pin_model (
  input wire logic mclk_i,
  input wire logic [5:0] hot_i,
  output logic [15:0] port_a_o,
  output logic [15:0] port_b_o,
  output logic [15:0] port_c_o,
  output logic [15:0] port_d_o
);
  logic [63:0] pins_q;
  // one pin high per selector code; unbonded positions driven too so a leak shows
  always_ff @(posedge mclk_i) begin
    pins_q <= 64'h1 << hot_i;
  end
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      port_a_o[p] = pins_q[4*p];
      port_b_o[p] = pins_q[4*p+1];
      port_c_o[p] = pins_q[4*p+2];
      port_d_o[p] = pins_q[4*p+3];
    end
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the line source select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eis_pkg::*;
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [5:0] hot = 6'h00;
  logic [15:0] pa, pb, pc, pd;
  logic [3:0] lvl;
  logic [24:0] tol;
  int fail_count = 0, check_count = 0;
  always #25 mclk = ~mclk;
  eis_pin_model pm (.mclk_i(mclk), .hot_i(hot), .port_a_o(pa), .port_b_o(pb), .port_c_o(pc),
    .port_d_o(pd));
  eis_top uut (.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .port_a_i(pa), .port_b_i(pb), .port_c_i(pc), .port_d_i(pd),
    .line_level_o(lvl), .tolerance_enable_n_o(tol));
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  function automatic logic routed(input logic [5:0] c);
    case (c[1:0])
      EIS_PORT_C: return c[5:2] >= 4'hD;
      EIS_PORT_D: return c[5:2] == 4'h0 || c[5:2] >= 4'hC;
      default: return 1'b1;
    endcase
  endfunction
  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task t_reset;
    rd_reg(EIS_OFF_SEL, d);
    check(d, 32'h00000000);
    rd_reg(EIS_OFF_TOL, d);
    check(d, 32'h00000000);
    check({28'h0, lvl}, 32'h0000000F);
  endtask
  task t_tol;
    wr_reg(EIS_OFF_TOL, 32'hFFFFFFFF);
    rd_reg(EIS_OFF_TOL, d);
    check(d, 32'h01FFFFFF);
    check({7'h0, tol}, 32'h01FFFFFF);
    wr_reg(EIS_OFF_TOL, 32'h00AAAAAA);
    rd_reg(8'h18, d);
    check(d, 32'h00000000);
    check({7'h0, tol}, 32'h00AAAAAA);
  endtask
  task t_fields;
    // software keeps the gaps between selectors at zero
    wr_reg(EIS_OFF_SEL, 32'h3F3F3F3F);
    rd_reg(EIS_OFF_SEL, d);
    check(d, 32'h3F3F3F3F);
    for (int g = 0; g < 4; g++) begin
      wr_reg(EIS_OFF_SEL, 32'h0000003F << (8 * g));
      // new route must show one edge after the write edge
      @(posedge mclk);
      #1;
      check({28'h0, lvl}, 32'h1 << g);
    end
  endtask
  task t_codes;
    for (int c = 0; c < 64; c++) begin
      wr_reg(EIS_OFF_SEL, {4{2'h0, 6'(c)}});
      hot <= 6'(c);
      settle;
      check({28'h0, lvl}, {28'h0, {4{routed(6'(c))}}});
    end
  endtask
  // mid-run reset must bring back the power-on state after writes
  task t_rereset;
    @(posedge mclk);
    rst_n <= 1'b0;
    hot <= 6'h00;
    @(posedge mclk);
    #1;
    check({7'h0, tol}, 32'h00000000);
    check({28'h0, lvl}, 32'h00000000);
    @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_tol;
    hot <= 6'h3F;
    t_fields;
    t_codes;
    t_rereset;
    report_and_stop;
  end
endmodule
`default_nettype wire
